// [core/ssr_pkg.sv]
// Package with register map, field layout, reset values and carrier types of the receiver.
package ssr_pkg;

	// Register byte offsets on the register bus.
	localparam logic [7:0] OFS_RX_STATUS = 8'h00;
	localparam logic [7:0] OFS_TX_STATUS = 8'h04;
	localparam logic [7:0] OFS_BAUD = 8'h08;
	localparam logic [7:0] OFS_RX_DATA = 8'h0c;
	localparam logic [7:0] OFS_TX_DATA = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h1c;

	// Field positions in receive_status_control.
	localparam int BIT_PORT_EN = 7;
	localparam int BIT_NINE_EN = 6;
	localparam int BIT_SINGLE_EN = 5;
	localparam int BIT_CONT_EN = 4;
	localparam int BIT_ADDR_DET = 3;
	localparam int BIT_FRAME_ERR = 2;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_NINTH = 0;

	// Field positions in transmit_status_control.
	localparam int BIT_MASTER_CLK = 7;
	localparam int BIT_SYNC_MODE = 4;
	localparam int BIT_TX_EMPTY = 1;

	// Field positions in the interrupt registers.
	localparam int BIT_RX_IRQ = 5;
	localparam int BIT_GLOBAL_IRQ = 7;
	localparam int BIT_PERIPH_IRQ = 6;

	// Reset values and writable bits.
	localparam logic [7:0] RST_TX_STATUS = 8'h02;
	localparam logic [7:0] TX_STATUS_WR_MASK = 8'hf5;
	localparam logic [7:0] RST_BAUD = 8'h00;
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_IRQ_CTRL = 8'h00;

	// Character lengths and queue depth.
	localparam logic [3:0] CHAR_BITS_SHORT = 4'h8;
	localparam logic [3:0] CHAR_BITS_LONG = 4'h9;
	localparam int QUEUE_DEPTH = 2;

	typedef struct packed {
		logic port_en;
		logic nine_en;
		logic single_en;
		logic cont_en;
		logic addr_det;
	} rx_ctrl_t;

	typedef struct packed {
		logic ninth;
		logic [7:0] low;
	} rx_char_t;

	localparam rx_ctrl_t RST_RX_CTRL = '0;

endpackage : ssr_pkg

// [core/pin_sync.sv]
// Two-stage synchroniser for an outside pin, with edge pulses taken after the second stage.
`timescale 1ns/1ps
module pin_sync (
	input wire logic clock_in, // System clock.
	input wire logic nrst_in, // Asynchronous reset, active low.
	input wire logic pin_in, // Asynchronous pin level.
	output logic level_out, // Synchronised level.
	output logic rise_out, // One-cycle pulse on a rising edge.
	output logic fall_out // One-cycle pulse on a falling edge.
);
	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			meta_reg <= 1'b0;
			level_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= pin_in;
			level_reg <= meta_reg;
			prev_reg <= level_reg;
		end
	end

	assign level_out = level_reg;
	assign rise_out = level_reg & ~prev_reg;
	assign fall_out = ~level_reg & prev_reg;

endmodule : pin_sync

// [core/sync_serial_receiver.sv]
// Synchronous serial receive path with a two-character queue and a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module sync_serial_receiver
	import ssr_pkg::*;
#(
	parameter int QUEUE_DEPTH_P = QUEUE_DEPTH
) (
	input wire logic clock_in, // System clock, 200 MHz.
	input wire logic nrst_in, // Asynchronous reset, active low.
	input wire logic wb_cyc_in, // Wishbone cycle.
	input wire logic wb_stb_in, // Wishbone strobe.
	input wire logic wb_we_in, // Wishbone write enable.
	input wire logic [7:0] wb_adr_in, // Wishbone byte address.
	input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_in, // Wishbone write data.
	output logic [31:0] wb_dat_out, // Wishbone read data.
	output logic wb_ack_out, // Wishbone acknowledge.
	input wire logic transmit_clock_pin_in, // Shift clock pin level.
	output logic transmit_clock_pin_out, // Shift clock driven as master.
	output logic transmit_clock_pin_oe_n_out, // Clock pin driver enable, low drives.
	input wire logic receive_data_pin_in, // Serial data pin level.
	output logic receive_data_pin_out, // Data pin drive value.
	output logic receive_data_pin_oe_n_out, // Data pin driver enable, low drives.
	output logic irq_out // Receive interrupt request.
);
	localparam int PW = (QUEUE_DEPTH_P > 1) ? $clog2(QUEUE_DEPTH_P) : 1;
	localparam int CW = $clog2(QUEUE_DEPTH_P + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH_P);

	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction : byte_word

	function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] a, input logic [CW-1:0] b);
		logic [CW:0] sum;
		sum = (CW + 1)'(a) + (CW + 1)'(b);
		if (sum >= (CW + 1)'(QUEUE_DEPTH_P))
		begin
			sum = sum - (CW + 1)'(QUEUE_DEPTH_P);
		end
		wrap_add = PW'(sum);
	endfunction : wrap_add

	// Register state.
	rx_ctrl_t rx_ctrl_reg;
	rx_ctrl_t rx_ctrl_next;
	logic [7:0] tx_status_reg;
	logic [7:0] baud_reg;
	logic [7:0] irq_en_reg;
	logic [7:0] irq_ctrl_reg;
	logic overrun_reg;
	logic overrun_next;
	logic overrun_single_reg;

	// Receive engine and queue state.
	rx_char_t queue_mem [QUEUE_DEPTH_P];
	logic [PW-1:0] head_reg;
	logic [CW-1:0] count_reg;
	logic [8:0] shifter_reg;
	logic [8:0] shifter_fill;
	logic [3:0] bit_cnt_reg;
	logic [7:0] div_cnt_reg;
	logic strobe_reg;

	// Output flops.
	logic ack_reg;
	logic [31:0] dat_reg;
	logic irq_reg;
	logic clk_oe_n_reg;
	logic data_out_reg;
	logic data_oe_n_reg;

	// Synchronised pins.
	logic clk_fall;
	logic data_level;

	pin_sync clk_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.pin_in(transmit_clock_pin_in),
		.level_out(),
		.rise_out(),
		.fall_out(clk_fall)
	);

	pin_sync data_sync (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.pin_in(receive_data_pin_in),
		.level_out(data_level),
		.rise_out(),
		.fall_out()
	);

	// Bus decode. Writes, reads with side effects and pops act on the edge that sees ack.
	wire wb_req = wb_cyc_in & wb_stb_in;
	wire wb_fire = wb_req & ack_reg;
	wire wb_wr = wb_fire & wb_we_in & wb_sel_in[0];
	wire wb_rd = wb_fire & ~wb_we_in;
	wire hit_rx_status = (wb_adr_in == OFS_RX_STATUS);
	wire hit_tx_status = (wb_adr_in == OFS_TX_STATUS);
	wire hit_baud = (wb_adr_in == OFS_BAUD);
	wire hit_rx_data = (wb_adr_in == OFS_RX_DATA);
	wire hit_irq_en = (wb_adr_in == OFS_IRQ_EN);
	wire hit_irq_flag = (wb_adr_in == OFS_IRQ_FLAG);
	wire hit_irq_ctrl = (wb_adr_in == OFS_IRQ_CTRL);
	wire wr_rx_status = wb_wr & hit_rx_status;
	wire [7:0] wr_byte = wb_dat_in[7:0];

	// Mode decode.
	wire sync_mode = tx_status_reg[BIT_SYNC_MODE];
	wire master_mode = tx_status_reg[BIT_MASTER_CLK];
	wire unit_on = rx_ctrl_reg.port_en & sync_mode;
	wire receive_go = unit_on & (rx_ctrl_reg.single_en | rx_ctrl_reg.cont_en)
		& ~overrun_reg;
	wire [3:0] char_len = rx_ctrl_reg.nine_en ? CHAR_BITS_LONG : CHAR_BITS_SHORT;

	// Shift clock generation and trailing-edge detection.
	wire tick = receive_go & master_mode & (div_cnt_reg == baud_reg);
	wire master_trail = tick & strobe_reg;
	wire slave_trail = receive_go & ~master_mode & clk_fall;
	wire sample = master_trail | slave_trail;
	wire char_done = sample & (bit_cnt_reg == (char_len - 4'h1));

	// Queue control.
	rx_char_t head_char;
	rx_char_t new_char;
	wire queue_full = (count_reg == DEPTH_C);
	wire queue_any = (count_reg != '0);
	wire push = char_done & ~queue_full;
	wire overrun_set = char_done & queue_full;
	wire pop = wb_rd & hit_rx_data & queue_any;
	wire [PW-1:0] tail_idx = wrap_add(head_reg, count_reg);
	wire rx_flag = queue_any;

	assign head_char = queue_mem[head_reg];

	always_comb
	begin
		shifter_fill = shifter_reg;
		shifter_fill[bit_cnt_reg] = data_level;
	end

	assign new_char.ninth = rx_ctrl_reg.nine_en & shifter_fill[8];
	assign new_char.low = shifter_fill[7:0];

	// Overrun clears by a buffer read after a single receive, or by a continuous clear.
	wire overrun_clr = (pop & overrun_single_reg)
		| (wr_rx_status & ~wr_byte[BIT_CONT_EN]);

	assign overrun_next = overrun_set | (overrun_reg & ~overrun_clr);

	always_comb
	begin
		rx_ctrl_next = rx_ctrl_reg;
		if (char_done)
		begin
			rx_ctrl_next.single_en = 1'b0;
		end
		if (wr_rx_status)
		begin
			rx_ctrl_next.port_en = wr_byte[BIT_PORT_EN];
			rx_ctrl_next.nine_en = wr_byte[BIT_NINE_EN];
			rx_ctrl_next.single_en = wr_byte[BIT_SINGLE_EN];
			rx_ctrl_next.cont_en = wr_byte[BIT_CONT_EN];
			rx_ctrl_next.addr_det = wr_byte[BIT_ADDR_DET];
		end
	end

	// Read data selection.
	logic [7:0] rx_status_byte;
	logic [7:0] tx_status_byte;
	logic [7:0] irq_flag_byte;

	always_comb
	begin
		rx_status_byte = 8'h00;
		rx_status_byte[BIT_PORT_EN] = rx_ctrl_reg.port_en;
		rx_status_byte[BIT_NINE_EN] = rx_ctrl_reg.nine_en;
		rx_status_byte[BIT_SINGLE_EN] = rx_ctrl_reg.single_en;
		rx_status_byte[BIT_CONT_EN] = rx_ctrl_reg.cont_en;
		rx_status_byte[BIT_ADDR_DET] = rx_ctrl_reg.addr_det;
		rx_status_byte[BIT_FRAME_ERR] = 1'b0;
		rx_status_byte[BIT_OVERRUN] = overrun_reg;
		// An empty queue reports a clear ninth bit instead of stale or unknown storage.
		rx_status_byte[BIT_NINTH] = queue_any & head_char.ninth;
		tx_status_byte = tx_status_reg;
		tx_status_byte[BIT_TX_EMPTY] = 1'b1;
		irq_flag_byte = 8'h00;
		irq_flag_byte[BIT_RX_IRQ] = rx_flag;
	end

	wire [31:0] rd_word = hit_rx_status ? byte_word(rx_status_byte)
		: hit_tx_status ? byte_word(tx_status_byte)
		: hit_baud ? byte_word(baud_reg)
		: hit_rx_data ? byte_word(head_char.low)
		: hit_irq_en ? byte_word(irq_en_reg)
		: hit_irq_flag ? byte_word(irq_flag_byte)
		: hit_irq_ctrl ? byte_word(irq_ctrl_reg)
		: 32'h00000000;

	wire irq_next = rx_flag & irq_en_reg[BIT_RX_IRQ]
		& irq_ctrl_reg[BIT_GLOBAL_IRQ] & irq_ctrl_reg[BIT_PERIPH_IRQ];

	// Bus slave: ack one cycle after the request is seen, dropped the cycle after.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= wb_req & ~ack_reg;
			dat_reg <= (wb_req & ~ack_reg) ? rd_word : 32'h00000000;
		end
	end

	// Software-owned registers.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tx_status_reg <= RST_TX_STATUS;
			baud_reg <= RST_BAUD;
			irq_en_reg <= RST_IRQ_EN;
			irq_ctrl_reg <= RST_IRQ_CTRL;
		end
		else if (wb_wr)
		begin
			if (hit_tx_status)
			begin
				tx_status_reg <= (wr_byte & TX_STATUS_WR_MASK) | RST_TX_STATUS;
			end
			if (hit_baud)
			begin
				baud_reg <= wr_byte;
			end
			if (hit_irq_en)
			begin
				irq_en_reg <= wr_byte;
			end
			if (hit_irq_ctrl)
			begin
				irq_ctrl_reg <= wr_byte;
			end
		end
	end

	// Receive control and overrun state; a disabled port holds the unit in reset.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rx_ctrl_reg <= RST_RX_CTRL;
			overrun_reg <= 1'b0;
			overrun_single_reg <= 1'b0;
		end
		else
		begin
			rx_ctrl_reg <= rx_ctrl_next;
			overrun_reg <= rx_ctrl_reg.port_en & overrun_next;
			if (overrun_set)
			begin
				overrun_single_reg <= rx_ctrl_reg.single_en & ~rx_ctrl_reg.cont_en;
			end
		end
	end

	// Shift engine. Losing the go condition stops the clock and discards the partial character.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			shifter_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			div_cnt_reg <= 8'h00;
			strobe_reg <= 1'b0;
		end
		else if (!receive_go)
		begin
			shifter_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			div_cnt_reg <= 8'h00;
			strobe_reg <= 1'b0;
		end
		else
		begin
			div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
			if (tick)
			begin
				strobe_reg <= ~strobe_reg;
			end
			if (char_done)
			begin
				shifter_reg <= 9'h000;
				bit_cnt_reg <= 4'h0;
			end
			else if (sample)
			begin
				shifter_reg <= shifter_fill;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Receive queue. Data already queued is never overwritten on overrun.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			head_reg <= '0;
			count_reg <= '0;
		end
		else if (!rx_ctrl_reg.port_en)
		begin
			head_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (pop)
			begin
				head_reg <= wrap_add(head_reg, CW'(1));
			end
			if (push & ~pop)
			begin
				count_reg <= count_reg + CW'(1);
			end
			else if (pop & ~push)
			begin
				count_reg <= count_reg - CW'(1);
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (push)
		begin
			queue_mem[tail_idx] <= new_char;
		end
	end

	// Pin drivers and interrupt.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			clk_oe_n_reg <= 1'b1;
			data_out_reg <= 1'b0;
			data_oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end
		else
		begin
			clk_oe_n_reg <= ~(unit_on & master_mode);
			data_out_reg <= 1'b0;
			data_oe_n_reg <= 1'b1;
			irq_reg <= irq_next;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = dat_reg;
	assign transmit_clock_pin_out = strobe_reg;
	assign transmit_clock_pin_oe_n_out = clk_oe_n_reg;
	assign receive_data_pin_out = data_out_reg;
	assign receive_data_pin_oe_n_out = data_oe_n_reg;
	assign irq_out = irq_reg;

endmodule : sync_serial_receiver

// [tb/ssr_checker.sv]
// Port-level assertions for the synchronous serial receiver.
`timescale 1ns/1ps
module ssr_checker
	import ssr_pkg::*;
(
	input wire logic clock_in, // Clock.
	input wire logic nrst_in, // Reset.
	input wire logic wb_cyc_in, // Cycle.
	input wire logic wb_stb_in, // Strobe.
	input wire logic wb_we_in, // Write.
	input wire logic [7:0] wb_adr_in, // Address.
	input wire logic [3:0] wb_sel_in, // Selects.
	input wire logic [31:0] wb_dat_in, // Write data.
	input wire logic [31:0] wb_dat_out, // Read data.
	input wire logic wb_ack_out, // Ack.
	input wire logic transmit_clock_pin_in, // Clock pin.
	input wire logic transmit_clock_pin_out, // Clock drive.
	input wire logic transmit_clock_pin_oe_n_out, // Clock enable.
	input wire logic receive_data_pin_in, // Data pin.
	input wire logic receive_data_pin_out, // Data drive.
	input wire logic receive_data_pin_oe_n_out, // Data enable.
	input wire logic irq_out // Interrupt.
);
	logic wr;
	logic gate;
	logic slave_cfg;
	logic [7:0] tx_reg;
	logic [7:0] baud_reg;
	logic [7:0] en_reg;
	logic [7:0] ctl_reg;
	logic [8:0] hi_reg;
	assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];
	assign gate = en_reg[BIT_RX_IRQ] && ctl_reg[BIT_GLOBAL_IRQ] && ctl_reg[BIT_PERIPH_IRQ];
	assign slave_cfg = tx_reg[BIT_SYNC_MODE] && !tx_reg[BIT_MASTER_CLK];
	// Shadows of written registers and the length of the current clock high phase.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tx_reg <= RST_TX_STATUS;
			baud_reg <= RST_BAUD;
			en_reg <= RST_IRQ_EN;
			ctl_reg <= RST_IRQ_CTRL;
			hi_reg <= 9'h000;
		end
		else
		begin
			tx_reg <= (wr && wb_adr_in == OFS_TX_STATUS) ? wb_dat_in[7:0] : tx_reg;
			baud_reg <= (wr && wb_adr_in == OFS_BAUD) ? wb_dat_in[7:0] : baud_reg;
			en_reg <= (wr && wb_adr_in == OFS_IRQ_EN) ? wb_dat_in[7:0] : en_reg;
			ctl_reg <= (wr && wb_adr_in == OFS_IRQ_CTRL) ? wb_dat_in[7:0] : ctl_reg;
			hi_reg <= transmit_clock_pin_out ? hi_reg + 9'h001 : 9'h000;
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);
	sequence s_request;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_rx_off;
		wr && wb_adr_in == OFS_RX_STATUS && !wb_dat_in[BIT_CONT_EN] && !wb_dat_in[BIT_SINGLE_EN];
	endsequence
	property p_ack_answer;
		s_request |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack pulse wrong");
	property p_data_pin_off;
		receive_data_pin_oe_n_out;
	endproperty
	a_data_pin_off: assert property (p_data_pin_off) else $error("data pin driven");
	property p_upper_zero;
		wb_ack_out |-> wb_dat_out[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits");
	property p_half_period;
		$fell(transmit_clock_pin_out) && !$past(wr) && !$past(wr, 2)
			|-> hi_reg == {1'b0, baud_reg} + 9'h001;
	endproperty
	a_half_period: assert property (p_half_period) else $error("clock high phase");
	property p_slave_clk_off;
		slave_cfg && $past(slave_cfg) |-> transmit_clock_pin_oe_n_out;
	endproperty
	a_slave_clk_off: assert property (p_slave_clk_off) else $error("clock driven as slave");
	property p_irq_gate;
		!gate && !$past(gate) |-> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while gated");
	property p_flag_holds;
		irq_out && gate && !wb_ack_out && !$past(wb_ack_out) |=> irq_out;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("irq dropped");
	property p_stop;
		s_rx_off |-> ##2 (!transmit_clock_pin_out) [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("clock not stopped");
endmodule : ssr_checker
bind sync_serial_receiver ssr_checker chk_u (.clock_in(clock_in), .nrst_in(nrst_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .transmit_clock_pin_in(transmit_clock_pin_in),
	.transmit_clock_pin_out(transmit_clock_pin_out),
	.transmit_clock_pin_oe_n_out(transmit_clock_pin_oe_n_out),
	.receive_data_pin_in(receive_data_pin_in), .receive_data_pin_out(receive_data_pin_out),
	.receive_data_pin_oe_n_out(receive_data_pin_oe_n_out), .irq_out(irq_out));

// [tb/serial_peer.sv]
// Model of the external synchronous serial partner.
`timescale 1ns/1ps
module serial_peer (
	input wire logic line_clk_in, // Clock on the wire.
	input wire logic slave_in, // Partner makes the clock.
	input wire logic go_in, // Starts one character.
	input wire logic [8:0] word_in, // Character.
	input wire logic [3:0] nbits_in, // Bits per character.
	output logic data_out, // Data line.
	output logic clk_out // Clock as master.
);
	int idx = 0;
	initial
	begin
		data_out = 1'b0;
		clk_out = 1'b0;
	end
	// Each bit goes out on the leading edge, LSB first.
	always @(posedge line_clk_in)
	begin
		if (!slave_in)
		begin
			data_out = word_in[idx];
			idx = (idx + 1) % nbits_in;
		end
	end
	// Between characters the line shows the inverse of the last bit.
	always @(negedge line_clk_in)
	begin
		if (!slave_in && idx == 0)
			data_out = ~data_out;
	end
	// As clock master, one pulse per data bit and no more.
	always @(posedge go_in)
	begin
		#1.3;
		for (int i = 0; i < nbits_in; i++)
		begin
			clk_out = 1'b1;
			data_out = word_in[i];
			#62.5;
			clk_out = 1'b0;
			#62.5;
		end
		data_out = ~data_out;
	end
endmodule : serial_peer

// [tb/sync_serial_receiver_tb_top.sv]
// Self-checking bench for the synchronous serial receiver.
`timescale 1ns/1ps
module sync_serial_receiver_tb_top;
	import ssr_pkg::*;
	logic clock_in, nrst_in, cyc, stb, we, ack, ck_o, ck_oe_n, dt_o, dt_oe_n, irq;
	logic slave, go, pdat, pclk;
	logic [7:0] adr;
	logic [3:0] sel, nbits;
	logic [31:0] wdat, rdat;
	logic [8:0] word;
	wire ck_line;
	int checks = 0;
	int bad_count = 0;
	assign ck_line = ck_oe_n ? pclk : ck_o;
	sync_serial_receiver dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .transmit_clock_pin_in(ck_line),
		.transmit_clock_pin_out(ck_o), .transmit_clock_pin_oe_n_out(ck_oe_n),
		.receive_data_pin_in(dt_oe_n ? pdat : dt_o), .receive_data_pin_out(dt_o),
		.receive_data_pin_oe_n_out(dt_oe_n), .irq_out(irq));
	serial_peer peer_u (.line_clk_in(ck_line), .slave_in(slave), .go_in(go), .word_in(word),
		.nbits_in(nbits), .data_out(pdat), .clk_out(pclk));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clock_in);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clock_in);
			n++;
		end
		q = rdat;
		if (ack !== 1'b1)
		begin
			bad_count++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock_in);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check(q, {24'h000000, e});
	endtask : rdc
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		logic [31:0] q;
		int n;
		n = 0;
		q = ~{32{v}};
		while (q[b] !== v && n < 300)
		begin
			bus(1'b0, a, 8'h00, q);
			n++;
		end
		if (q[b] !== v)
		begin
			bad_count++;
			$display("unexpected at %0t: status bit never came", $time);
		end
	endtask : wait_bit
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	initial
	begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	initial
	begin
		#200000;
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		final_report();
	end
	initial
	begin
		{nrst_in, cyc, stb, we, slave, go, adr, wdat} = '0;
		sel = 4'h1;
		nbits = 4'h8;
		word = 9'h0a5;
		repeat (2) @(posedge clock_in);
		nrst_in <= 1'b1;
		@(posedge clock_in);
		rdc(OFS_TX_STATUS, RST_TX_STATUS);
		rdc(OFS_BAUD, RST_BAUD);
		rdc(OFS_IRQ_EN, RST_IRQ_EN);
		rdc(OFS_IRQ_CTRL, RST_IRQ_CTRL);
		rdc(OFS_RX_STATUS, 8'h00);
		rdc(8'h20, 8'h00);
		$display("test reset done");
		wr(OFS_BAUD, 8'h03);
		wr(OFS_TX_STATUS, 8'h90);
		wr(OFS_IRQ_EN, 8'h20);
		wr(OFS_IRQ_CTRL, 8'hc0);
		wr(OFS_RX_STATUS, 8'ha0);
		wait_bit(OFS_IRQ_FLAG, BIT_RX_IRQ, 1'b1);
		rdc(OFS_RX_STATUS, 8'h80);
		check({31'h0, irq}, 32'h1);
		check({29'h0, ck_oe_n, dt_oe_n, dt_o}, 32'h2);
		wr(OFS_IRQ_EN, 8'h00);
		repeat (2) @(posedge clock_in);
		check({31'h0, irq}, 32'h0);
		rdc(OFS_RX_DATA, 8'ha5);
		rdc(OFS_IRQ_FLAG, 8'h00);
		$display("test single done");
		word <= 9'h03c;
		wr(OFS_RX_STATUS, 8'h90);
		wait_bit(OFS_RX_STATUS, BIT_OVERRUN, 1'b1);
		rdc(OFS_RX_STATUS, 8'h92);
		rdc(OFS_RX_DATA, 8'h3c);
		rdc(OFS_RX_STATUS, 8'h92);
		rdc(OFS_RX_DATA, 8'h3c);
		repeat (150) @(posedge clock_in);
		rdc(OFS_IRQ_FLAG, 8'h00);
		wr(OFS_RX_STATUS, 8'h80);
		rdc(OFS_RX_STATUS, 8'h80);
		$display("test continuous done");
		word <= 9'h1c3;
		nbits <= 4'h9;
		wr(OFS_RX_STATUS, 8'hf0);
		wait_bit(OFS_RX_STATUS, BIT_OVERRUN, 1'b1);
		rdc(OFS_RX_STATUS, 8'hd3);
		rdc(OFS_RX_DATA, 8'hc3);
		wr(OFS_RX_STATUS, 8'h00);
		rdc(OFS_RX_STATUS, 8'h00);
		rdc(OFS_IRQ_FLAG, 8'h00);
		$display("test nine bit done");
		word <= 9'h055;
		nbits <= 4'h8;
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_RX_STATUS, 8'ha0);
			wait_bit(OFS_RX_STATUS, BIT_SINGLE_EN, 1'b0);
		end
		rdc(OFS_RX_STATUS, 8'h82);
		rdc(OFS_RX_DATA, 8'h55);
		rdc(OFS_RX_STATUS, 8'h80);
		rdc(OFS_IRQ_FLAG, 8'h20);
		wr(OFS_RX_STATUS, 8'h00);
		wr(OFS_RX_STATUS, 8'h90);
		repeat (20) @(posedge clock_in);
		wr(OFS_RX_STATUS, 8'h80);
		repeat (100) @(posedge clock_in);
		rdc(OFS_IRQ_FLAG, 8'h00);
		$display("test overrun done");
		wr(OFS_TX_STATUS, 8'h10);
		slave <= 1'b1;
		word <= 9'h096;
		wr(OFS_RX_STATUS, 8'ha0);
		go <= 1'b1;
		wait_bit(OFS_IRQ_FLAG, BIT_RX_IRQ, 1'b1);
		check({31'h0, ck_oe_n}, 32'h1);
		rdc(OFS_RX_STATUS, 8'h80);
		rdc(OFS_RX_DATA, 8'h96);
		$display("test slave done");
		final_report();
	end
endmodule : sync_serial_receiver_tb_top
